// >>> common/switch_prio_regen_learn_irq_consts.vh
// Function
// - port 2 table holds eight 3-bit fields, priority n at bits 3n+2:3n
// - received port 2 VLAN priority is replaced by its table entry for queue choice
// - after reset every table entry equals its own index, 7h down to 0h
// - per-port 32-bit counter of source addresses not learned or overwritten
// - reading a learn-discard counter returns the count and clears it; resets to zero
// - learn-discard counters stop at all ones and never wrap
// - mask bit 0 blocks all switch interrupts when set; resets set
// - mask only stops propagation; pending bits keep capturing events
// - pending status is one register; a read clears it but keeps events of the read cycle
`ifndef SWITCH_PRIO_REGEN_LEARN_IRQ_CONSTS_VH
`define SWITCH_PRIO_REGEN_LEARN_IRQ_CONSTS_VH

`define ADDR_W                16
`define REG_REGEN_TABLE_P2    16'h1857
`define REG_LEARN_DISCARD_P0  16'h1858
`define REG_LEARN_DISCARD_P1  16'h1859
`define REG_LEARN_DISCARD_P2  16'h185a
`define REG_IRQ_MASK          16'h1880
`define REG_IRQ_PENDING       16'h1881

`define PRIO_W                3
`define PRIO_COUNT            8
`define REGEN_TABLE_W         24
`define REGEN_TABLE_RESET     24'hfa_c688
`define LEARN_COUNT_W         32
`define LEARN_COUNT_RESET     32'h0000_0000
`define LEARN_COUNT_MAX       32'hffff_ffff
`define IRQ_MASK_BIT          0
`define IRQ_MASK_RESET        1'h1
`define DATA_W                32

`endif

// >>> hw/learn_discard_counter.v
`timescale 1ns/100ps
`default_nettype none
`include "switch_prio_regen_learn_irq_consts.vh"

module learn_discard_counter (
    input  wire                        clock,      // core clock
    input  wire                        rst,        // synchronous reset
    input  wire                        discard,    // one address not learned or overwritten
    input  wire                        read_clear, // software read of this counter
    output reg  [`LEARN_COUNT_W-1:0]   count_r     // current count
);

    reg [`LEARN_COUNT_W-1:0] count_nxt;

    always @* begin
        count_nxt = count_r;
        if (read_clear) begin
            // an event in the read cycle is not lost: it starts the new count
            count_nxt = discard ? {{(`LEARN_COUNT_W-1){1'b0}}, 1'b1} : `LEARN_COUNT_RESET;
        end else if (discard && count_r != `LEARN_COUNT_MAX) begin
            count_nxt = count_r + {{(`LEARN_COUNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            count_r <= `LEARN_COUNT_RESET;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule
`default_nettype wire

// >>> hw/switch_prio_regen_learn_irq.v
`timescale 1ns/100ps
`default_nettype none
`include "switch_prio_regen_learn_irq_consts.vh"

module switch_prio_regen_learn_irq #(
    parameter IRQ_W = 16                              // number of switch interrupt sources
) (
    input  wire                       clock,           // core clock, 40 MHz
    input  wire                       rst,             // synchronous reset, active high
    input  wire [`ADDR_W-1:0]         reg_addr,        // register number
    input  wire                       reg_wr,          // write strobe
    input  wire                       reg_rd,          // read strobe
    input  wire [`DATA_W-1:0]         reg_wdata,       // write data
    output reg  [`DATA_W-1:0]         reg_rdata,       // read data
    output reg                        reg_rvalid,      // read data valid pulse
    input  wire                       rx_prio_valid,   // port 2 frame priority valid
    input  wire [`PRIO_W-1:0]         rx_prio,         // received VLAN priority
    output reg                        regen_prio_valid, // regenerated priority valid
    output reg  [`PRIO_W-1:0]         regen_prio,      // priority for queue choice
    input  wire [2:0]                 learn_discard,   // per-port discard events
    input  wire [IRQ_W-1:0]           irq_event,       // switch interrupt events
    output reg                        irq_request      // switch interrupt request
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function [`PRIO_W-1:0] prio_field;
        input [`REGEN_TABLE_W-1:0] tbl;
        input [`PRIO_W-1:0]        index;
        begin
            prio_field = tbl[index*`PRIO_W +: `PRIO_W];
        end
    endfunction

    function hit;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    reg  [`REGEN_TABLE_W-1:0] regen_table_r;
    reg  [`REGEN_TABLE_W-1:0] regen_table_nxt;
    reg                       irq_mask_r;
    reg                       irq_mask_nxt;
    reg  [IRQ_W-1:0]          pending_r;
    reg  [IRQ_W-1:0]          pending_nxt;
    reg  [`DATA_W-1:0]        rdata_nxt;
    wire [`LEARN_COUNT_W-1:0] count0;
    wire [`LEARN_COUNT_W-1:0] count1;
    wire [`LEARN_COUNT_W-1:0] count2;
    wire [2:0]                count_clear;

    wire rd_pending = reg_rd && hit(reg_addr, `REG_IRQ_PENDING);

    assign count_clear[0] = reg_rd && hit(reg_addr, `REG_LEARN_DISCARD_P0);
    assign count_clear[1] = reg_rd && hit(reg_addr, `REG_LEARN_DISCARD_P1);
    assign count_clear[2] = reg_rd && hit(reg_addr, `REG_LEARN_DISCARD_P2);

    always @* begin
        regen_table_nxt = regen_table_r;
        irq_mask_nxt    = irq_mask_r;
        if (reg_wr && hit(reg_addr, `REG_REGEN_TABLE_P2)) begin
            regen_table_nxt = reg_wdata[`REGEN_TABLE_W-1:0];
        end
        if (reg_wr && hit(reg_addr, `REG_IRQ_MASK)) begin
            irq_mask_nxt = reg_wdata[`IRQ_MASK_BIT];
        end
    end

    // live status keeps catching events regardless of the mask; a read hands
    // the current set to software and restarts from events of that same cycle
    always @* begin
        if (rd_pending) begin
            pending_nxt = irq_event;
        end else begin
            pending_nxt = pending_r | irq_event;
        end
    end

    always @* begin
        rdata_nxt = {`DATA_W{1'b0}};
        case (reg_addr)
            `REG_REGEN_TABLE_P2:   rdata_nxt = {{(`DATA_W-`REGEN_TABLE_W){1'b0}},
                                                regen_table_r};
            `REG_LEARN_DISCARD_P0: rdata_nxt = count0;
            `REG_LEARN_DISCARD_P1: rdata_nxt = count1;
            `REG_LEARN_DISCARD_P2: rdata_nxt = count2;
            `REG_IRQ_MASK:         rdata_nxt = {{(`DATA_W-1){1'b0}}, irq_mask_r};
            `REG_IRQ_PENDING:      rdata_nxt = {{(`DATA_W-IRQ_W){1'b0}}, pending_r};
            default:               rdata_nxt = {`DATA_W{1'b0}};
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            regen_table_r    <= `REGEN_TABLE_RESET;
            irq_mask_r       <= `IRQ_MASK_RESET;
            pending_r        <= {IRQ_W{1'b0}};
            reg_rdata        <= {`DATA_W{1'b0}};
            reg_rvalid       <= 1'b0;
            regen_prio       <= {`PRIO_W{1'b0}};
            regen_prio_valid <= 1'b0;
            irq_request      <= 1'b0;
        end else begin
            regen_table_r    <= regen_table_nxt;
            irq_mask_r       <= irq_mask_nxt;
            pending_r        <= pending_nxt;
            reg_rdata        <= reg_rd ? rdata_nxt : {`DATA_W{1'b0}};
            reg_rvalid       <= reg_rd;
            regen_prio       <= prio_field(regen_table_r, rx_prio);
            regen_prio_valid <= rx_prio_valid;
            irq_request      <= (|pending_r) && !irq_mask_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // learn-discard counters

    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1) begin : g_count
            wire [`LEARN_COUNT_W-1:0] value;
            learn_discard_counter u_count (
                .clock      (clock),
                .rst        (rst),
                .discard    (learn_discard[p]),
                .read_clear (count_clear[p]),
                .count_r    (value)
            );
        end
    endgenerate

    assign count0 = g_count[0].value;
    assign count1 = g_count[1].value;
    assign count2 = g_count[2].value;

endmodule
`default_nettype wire

// >>> tb/regen_irq_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "switch_prio_regen_learn_irq_consts.vh"
module regen_irq_checker #(parameter IRQ_W = 16) (
    input wire logic               clock,            // clk
    input wire logic               rst,              // reset
    input wire logic [`ADDR_W-1:0] reg_addr,         // addr
    input wire logic               reg_wr,           // write
    input wire logic               reg_rd,           // read
    input wire logic [`DATA_W-1:0] reg_wdata,        // wdata
    input wire logic [`DATA_W-1:0] reg_rdata,        // rdata
    input wire logic               reg_rvalid,       // rvalid
    input wire logic               rx_prio_valid,    // prio in
    input wire logic               regen_prio_valid, // prio out
    input wire logic [2:0]         learn_discard,    // discards
    input wire logic [IRQ_W-1:0]   irq_event,        // events
    input wire logic               irq_request       // irq
);
    logic mask_r;
    always_ff @(posedge clock)
        if (rst) mask_r <= 1'b1;
        else if (reg_wr && reg_addr == `REG_IRQ_MASK) mask_r <= reg_wdata[0];
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
    a_regen_lag: assert property (rx_prio_valid |=> regen_prio_valid) else $error("lag");
    a_table_rsvd: assert property (reg_rvalid && $past(reg_addr) == `REG_REGEN_TABLE_P2
        |-> reg_rdata[31:24] == 8'h00) else $error("table top");
    a_mask_rsvd: assert property (reg_rvalid && $past(reg_addr) == `REG_IRQ_MASK
        |-> reg_rdata[31:1] == 31'h0) else $error("mask top");
    a_irq_masked: assert property (irq_request |-> !$past(mask_r)) else $error("masked");
    a_irq_raise: assert property (|irq_event ##1 !mask_r |=> irq_request)
        else $error("no irq");
    a_count_clear: assert property (reg_rd && reg_addr == `REG_LEARN_DISCARD_P0
        && !learn_discard[0] ##1 !learn_discard[0] ##1 reg_rd
        && reg_addr == `REG_LEARN_DISCARD_P0 |=> reg_rdata == '0) else $error("count");
    a_pend_clear: assert property (reg_rd && reg_addr == `REG_IRQ_PENDING
        && irq_event == '0 ##1 irq_event == '0 ##1 reg_rd
        && reg_addr == `REG_IRQ_PENDING |=> reg_rdata == '0) else $error("pending");
    c_irq: cover property ($rose(irq_request));
    c_count: cover property (reg_rvalid && reg_rdata == 32'h0000_0006);
    c_regen: cover property (regen_prio_valid);
endmodule
bind switch_prio_regen_learn_irq regen_irq_checker #(.IRQ_W(IRQ_W)) u_chk (.clock, .rst,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .rx_prio_valid,
    .regen_prio_valid, .learn_discard, .irq_event, .irq_request);
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "switch_prio_regen_learn_irq_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
    logic               clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_prio_valid = 0;
    logic [`ADDR_W-1:0] reg_addr = '0;
    logic [`DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic [2:0]         rx_prio = '0, regen_prio, learn_discard = '0;
    logic [15:0]        irq_event = '0;
    logic               reg_rvalid, regen_prio_valid, irq_request;
    int                 failures = 0, check_count = 0, i;
    always #12.5 clock = ~clock;
    switch_prio_regen_learn_irq u_switch_prio_regen_learn_irq (.clock, .rst, .reg_addr,
        .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .rx_prio_valid, .rx_prio,
        .regen_prio_valid, .regen_prio, .learn_discard, .irq_event, .irq_request);
    task conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one register access; events ride along with the strobe
    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [15:0] e);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        irq_event <= e;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        irq_event <= '0;
        #1;
        if (!w) `CHK({reg_rvalid, reg_rdata}, {1'b1, d})
    endtask
    task prio(input logic [23:0] t);
        for (i = 0; i < 8; i++) begin
            @(posedge clock);
            rx_prio_valid <= 1'b1;
            rx_prio <= i[2:0];
            @(posedge clock);
            rx_prio_valid <= 1'b0;
            #1 `CHK({regen_prio_valid, regen_prio}, {1'b1, t[3 * i +: 3]})
        end
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        xfer(0, `REG_REGEN_TABLE_P2, 32'h00fa_c688, '0);
        xfer(0, `REG_IRQ_MASK, 32'h0000_0001, '0);
        xfer(0, `REG_IRQ_PENDING, '0, '0);
        prio(24'hfa_c688);
        xfer(1, `REG_REGEN_TABLE_P2, 32'hff05_3977, '0);
        xfer(0, `REG_REGEN_TABLE_P2, 32'h0005_3977, '0);
        prio(24'h05_3977);
        $display("table test done");
        for (i = 0; i < 6; i++) @(posedge clock) learn_discard <= 3'b111 << (i / 2);
        @(posedge clock) learn_discard <= '0;
        for (i = 0; i < 3; i++) begin
            xfer(1, 16'(`REG_LEARN_DISCARD_P0 + i), '1, '0);
            xfer(0, 16'(`REG_LEARN_DISCARD_P0 + i), 32'(2 * i + 2), '0);
            xfer(0, 16'(`REG_LEARN_DISCARD_P0 + i), '0, '0);
        end
        $display("counter test done");
        xfer(0, 16'h1860, '0, 16'h0008);
        repeat (3) @(posedge clock);
        #1 `CHK(irq_request, 1'b0)
        xfer(1, `REG_IRQ_MASK, 32'hffff_fffe, '0);
        xfer(0, `REG_IRQ_MASK, '0, '0);
        `CHK(irq_request, 1'b1)
        xfer(0, `REG_IRQ_PENDING, 32'h0000_0008, 16'h0002);
        xfer(0, `REG_IRQ_PENDING, 32'h0000_0002, '0);
        xfer(0, `REG_IRQ_PENDING, '0, '0);
        `CHK(irq_request, 1'b0)
        $display("interrupt test done");
        conclude();
    end
endmodule
`default_nettype wire
